//--- hw/mie_pkg.sv
// shared constants for the move-instruction execute block
package mie_pkg;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  // field positions inside the instruction word
  localparam int FADDR_LSB = 0;
  localparam int DEST_BIT = 5;
  localparam int LIT_LSB = 0;
  // opcode masks and match patterns
  localparam logic [INSTR_W-1:0] COPY_MASK = 12'hfc0;
  localparam logic [INSTR_W-1:0] COPY_PAT = 12'h200;
  localparam logic [INSTR_W-1:0] LIT_MASK = 12'hf00;
  localparam logic [INSTR_W-1:0] LIT_PAT = 12'hc00;
  localparam logic [INSTR_W-1:0] STORE_MASK = 12'hfe0;
  localparam logic [INSTR_W-1:0] STORE_PAT = 12'h020;
  localparam logic [INSTR_W-1:0] OPT_WORD = 12'h002;
  // reset values
  localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
  localparam logic [FADDR_W-1:0] FADDR_RST = 5'h00;
  localparam logic [INSTR_W-1:0] INSTR_RST = 12'h000;
  // execute stage states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } mie_state_type;
endpackage

//--- hw/mie_dec_if.sv
`timescale 1ns/10ps
`default_nettype none
// decoded view of one instruction word
interface mie_dec_if;
  logic [mie_pkg::INSTR_W-1:0] instr;
  logic is_copy;
  logic is_lit;
  logic is_store;
  logic is_opt;
  logic dest_file;
  logic [mie_pkg::FADDR_W-1:0] faddr;
  logic [mie_pkg::DATA_W-1:0] lit;
  modport dec (input instr, output is_copy, is_lit, is_store, is_opt, dest_file, faddr, lit);
  modport exe (output instr, input is_copy, is_lit, is_store, is_opt, dest_file, faddr, lit);
endinterface
`default_nettype wire

//--- hw/mie_decoder.sv
`timescale 1ns/10ps
`default_nettype none
// pure pattern match; words that match nothing decode to no operation here
module mie_decoder (
  // decoded word
  mie_dec_if.dec d
);
  // field extraction and opcode match
  always_comb
  begin
    d.is_copy = (d.instr & mie_pkg::COPY_MASK) == mie_pkg::COPY_PAT;
    d.is_lit = (d.instr & mie_pkg::LIT_MASK) == mie_pkg::LIT_PAT;
    d.is_store = (d.instr & mie_pkg::STORE_MASK) == mie_pkg::STORE_PAT;
    d.is_opt = d.instr == mie_pkg::OPT_WORD;
    d.dest_file = d.instr[mie_pkg::DEST_BIT];
    d.faddr = d.instr[mie_pkg::FADDR_LSB +: mie_pkg::FADDR_W];
    d.lit = d.instr[mie_pkg::LIT_LSB +: mie_pkg::DATA_W];
  end
endmodule
`default_nettype wire

//--- hw/mie_exec.sv
`timescale 1ns/10ps
`default_nettype none
module mie_exec #(
  parameter logic [7:0] OPTION_RESET = 8'h00
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // instruction from fetch
  input wire logic instr_valid,
  input wire logic [mie_pkg::INSTR_W-1:0] instr_word,
  // file register read port
  output logic [mie_pkg::FADDR_W-1:0] file_rd_addr,
  input wire logic [mie_pkg::DATA_W-1:0] file_rd_data,
  // file register write port
  output logic file_wr_en,
  output logic [mie_pkg::FADDR_W-1:0] file_wr_addr,
  output logic [mie_pkg::DATA_W-1:0] file_wr_data,
  // architectural state
  output logic [mie_pkg::DATA_W-1:0] accum,
  output logic zero_flag,
  output logic zero_upd,
  output logic [mie_pkg::DATA_W-1:0] option_reg,
  // completion
  output logic done
);
  mie_pkg::mie_state_type st_q;
  mie_pkg::mie_state_type st_d;
  logic [mie_pkg::INSTR_W-1:0] ex_instr_q;
  logic [mie_pkg::INSTR_W-1:0] ex_instr_d;
  logic [mie_pkg::FADDR_W-1:0] rd_addr_q;
  logic [mie_pkg::FADDR_W-1:0] rd_addr_d;
  logic wen_q;
  logic wen_d;
  logic [mie_pkg::FADDR_W-1:0] waddr_q;
  logic [mie_pkg::FADDR_W-1:0] waddr_d;
  logic [mie_pkg::DATA_W-1:0] wdata_q;
  logic [mie_pkg::DATA_W-1:0] wdata_d;
  logic [mie_pkg::DATA_W-1:0] w_q;
  logic [mie_pkg::DATA_W-1:0] w_d;
  logic z_q;
  logic z_d;
  logic zupd_q;
  logic zupd_d;
  logic [mie_pkg::DATA_W-1:0] opt_q;
  logic [mie_pkg::DATA_W-1:0] opt_d;
  logic done_q;
  logic done_d;
  logic exec;
  logic fwd;
  logic [mie_pkg::DATA_W-1:0] src;

  mie_dec_if dif ();

  // decode the word held in the execute stage
  assign dif.instr = ex_instr_q;

  mie_decoder u_dec (
    .d (dif.dec)
  );

  // a write issued last cycle lands in the file only at this edge, so forward it
  assign exec = st_q == mie_pkg::ST_EXEC;
  assign fwd = wen_q && (waddr_q == dif.faddr);
  assign src = fwd ? wdata_q : file_rd_data;

  // fetch side: every word is taken, the read address is launched from a flop
  always_comb
  begin
    st_d = instr_valid ? mie_pkg::ST_EXEC : mie_pkg::ST_IDLE;
    ex_instr_d = instr_valid ? instr_word : ex_instr_q;
    rd_addr_d = instr_valid ? instr_word[mie_pkg::FADDR_LSB +: mie_pkg::FADDR_W] : rd_addr_q;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= mie_pkg::ST_IDLE;
      ex_instr_q <= mie_pkg::INSTR_RST;
      rd_addr_q <= mie_pkg::FADDR_RST;
    end
    else
    begin
      st_q <= st_d;
      ex_instr_q <= ex_instr_d;
      rd_addr_q <= rd_addr_d;
    end
  end

  // execute: one instruction per cycle, unknown words fall through untouched
  always_comb
  begin
    w_d = w_q;
    z_d = z_q;
    zupd_d = 1'b0;
    opt_d = opt_q;
    wen_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    done_d = 1'b0;
    if (exec)
    begin
      if (dif.is_copy)
      begin
        if (dif.dest_file)
        begin
          wen_d = 1'b1;
          waddr_d = dif.faddr;
          wdata_d = src;
        end
        else
        begin
          w_d = src;
        end
        z_d = src == mie_pkg::ZERO_DATA;
        zupd_d = 1'b1;
        done_d = 1'b1;
      end
      else if (dif.is_lit)
      begin
        w_d = dif.lit;
        done_d = 1'b1;
      end
      else if (dif.is_store)
      begin
        wen_d = 1'b1;
        waddr_d = dif.faddr;
        wdata_d = w_q;
        done_d = 1'b1;
      end
      else if (dif.is_opt)
      begin
        opt_d = w_q;
        done_d = 1'b1;
      end
      else
      begin
        done_d = 1'b0; // not ours: another unit executes it
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w_q <= mie_pkg::ACCUM_RST;
      z_q <= 1'b0;
      zupd_q <= 1'b0;
      opt_q <= OPTION_RESET;
      wen_q <= 1'b0;
      waddr_q <= mie_pkg::FADDR_RST;
      wdata_q <= mie_pkg::ZERO_DATA;
      done_q <= 1'b0;
    end
    else
    begin
      w_q <= w_d;
      z_q <= z_d;
      zupd_q <= zupd_d;
      opt_q <= opt_d;
      wen_q <= wen_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      done_q <= done_d;
    end
  end

  // outputs straight from flops
  assign file_rd_addr = rd_addr_q;
  assign file_wr_en = wen_q;
  assign file_wr_addr = waddr_q;
  assign file_wr_data = wdata_q;
  assign accum = w_q;
  assign zero_flag = z_q;
  assign zero_upd = zupd_q;
  assign option_reg = opt_q;
  assign done = done_q;

  // checks on the execute behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_copy_issue;
    instr_valid && ((instr_word & mie_pkg::COPY_MASK) == mie_pkg::COPY_PAT);
  endsequence

  sequence s_copy_result;
    done && zero_upd;
  endsequence

  AST_COPY_RDADDR: assert property (exec && dif.is_copy |-> file_rd_addr == dif.faddr)
    else $error("copy read address does not match the register field");

  AST_COPY_TO_ACC: assert property (
    exec && dif.is_copy && !dif.dest_file |=> accum == $past(src) && !file_wr_en)
    else $error("copy to accumulator wrong or touched the file");

  AST_COPY_TO_FILE: assert property (exec && dif.is_copy && dif.dest_file |=>
    file_wr_en && file_wr_addr == $past(dif.faddr) && file_wr_data == $past(src))
    else $error("copy back to file register wrong");

  AST_COPY_ZERO: assert property (exec && dif.is_copy |=>
    zero_upd && zero_flag == ($past(src) == mie_pkg::ZERO_DATA))
    else $error("zero flag not set from moved value");

  AST_COPY_LATENCY: assert property (s_copy_issue |-> ##2 s_copy_result)
    else $error("copy did not complete two cycles after issue");

  AST_LIT_LOAD: assert property (exec && dif.is_lit |=>
    accum == $past(dif.lit) && !zero_upd && $stable(zero_flag) && !file_wr_en)
    else $error("literal load wrong or flags changed");

  AST_STORE_ACC: assert property (exec && dif.is_store |=> file_wr_en &&
    file_wr_addr == $past(dif.faddr) && file_wr_data == $past(accum) && $stable(zero_flag))
    else $error("store of accumulator wrong");

  AST_OPT_LOAD: assert property (exec && dif.is_opt |=>
    option_reg == $past(accum) && !zero_upd && $stable(accum))
    else $error("option register not loaded from accumulator");
endmodule
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk;
  logic rstn;
  logic instr_valid;
  logic [11:0] instr_word;
  logic [4:0] file_rd_addr;
  logic [7:0] file_rd_data;
  logic file_wr_en;
  logic [4:0] file_wr_addr;
  logic [7:0] file_wr_data;
  logic [7:0] accum;
  logic zero_flag;
  logic zero_upd;
  logic [7:0] option_reg;
  logic done;
  logic [7:0] fmem [32];
  int err_total = 0;
  int total_checks = 0;
  // non-zero reset value so a reset that ignores the parameter shows up
  mie_exec #(.OPTION_RESET(8'h3c)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
    .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .accum(accum),
    .zero_flag(zero_flag), .zero_upd(zero_upd), .option_reg(option_reg), .done(done)
  );
  // file register model: combinational read, write on the edge
  assign file_rd_data = fmem[file_rd_addr];
  always @(posedge sys_clk)
  begin
    if (file_wr_en === 1'b1)
      fmem[file_wr_addr] <= file_wr_data;
  end
  // 100 mhz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one word for one cycle; returns just after the result edge, where pulses stand
  task automatic run(input logic [11:0] w);
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b1;
    instr_word = w;
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic test_literal();
    run(12'hc5a);
    chk(accum, 12'h05a, "literal accum");
    chk({done, zero_upd}, 12'h002, "literal done, no flag");
    $display("end of literal test");
  endtask
  task automatic test_store();
    run(12'h027);
    chk({file_wr_en, file_wr_addr}, 12'h027, "store write addr");
    chk(file_wr_data, 12'h05a, "store write data");
    chk({done, zero_upd}, 12'h002, "store done, no flag");
    $display("end of store test");
  endtask
  task automatic test_option();
    run(12'h002);
    chk(option_reg, 12'h05a, "option load");
    chk({done, zero_upd, file_wr_en}, 12'h004, "option pulses");
    $display("end of option test");
  endtask
  // copy to accumulator: nonzero then zero value, flag turns around between the two copies
  task automatic test_copy_accum();
    run(12'h203);
    chk(file_rd_addr, 12'h003, "copy read address");
    chk(accum, 12'h0a3, "copy accum");
    chk({zero_flag, zero_upd, done, file_wr_en}, 12'h006, "copy nonzero flags");
    run(12'h205);
    chk(accum, 12'h000, "copy zero accum");
    chk({zero_flag, zero_upd, done, file_wr_en}, 12'h00e, "copy zero flags");
    @(posedge sys_clk);
    #1;
    chk({zero_upd, done, zero_flag}, 12'h001, "pulses end, flag holds");
    chk(fmem[3], 12'h0a3, "source untouched");
    $display("end of copy to accumulator test");
  endtask
  // copy back to the file register leaves the accumulator alone
  task automatic test_copy_file();
    run(12'h229);
    chk({file_wr_en, file_wr_addr}, 12'h029, "copy back addr");
    chk(file_wr_data, 12'h0a9, "copy back data");
    chk(accum, 12'h000, "accum unchanged");
    chk({zero_flag, zero_upd}, 12'h001, "copy back flag");
    run(12'h225);
    chk({zero_flag, zero_upd, file_wr_en}, 12'h007, "copy back zero");
    $display("end of copy to file test");
  endtask
  // words close to the copy and store patterns must do nothing
  task automatic test_refused();
    run(12'h243);
    chk({done, file_wr_en, zero_upd}, 12'h000, "near copy refused");
    run(12'h007);
    chk({done, file_wr_en}, 12'h000, "near store refused");
    chk(option_reg, 12'h05a, "option kept");
    $display("end of refused test");
  endtask
  // words on consecutive cycles; the copy reads a register whose store has not landed yet
  task automatic test_back_to_back();
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b1;
    instr_word = 12'hc77;
    @(posedge sys_clk);
    #1;
    instr_word = 12'h02b;
    @(posedge sys_clk);
    #1;
    instr_word = 12'h22b;
    chk({accum, done}, 12'h0ef, "back to back literal");
    @(posedge sys_clk);
    #1;
    instr_valid = 1'b0;
    chk({file_wr_en, file_wr_addr}, 12'h02b, "back to back store addr");
    chk(file_wr_data, 12'h077, "back to back store data");
    @(posedge sys_clk);
    #1;
    chk({file_wr_en, file_wr_addr}, 12'h02b, "forwarded copy addr");
    chk(file_wr_data, 12'h077, "forwarded copy data");
    chk({zero_flag, zero_upd, done}, 12'h003, "forwarded copy flags");
    chk(fmem[11], 12'h077, "stored value landed");
    $display("end of back to back test");
  endtask
  // reset in mid-run: state set beforehand so the accum, zero flag and option reset values are real changes
  task automatic test_reset_mid();
    run(12'h225);
    chk({zero_flag, accum}, 12'h177, "zero set before reset");
    @(posedge sys_clk);
    #1;
    rstn = 1'b0;
    #1;
    chk({accum, zero_flag, file_wr_en, done}, 12'h000, "mid reset clears");
    chk(option_reg, 12'h03c, "mid reset option");
    @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    run(12'h002);
    chk({option_reg, done}, 12'h001, "option after reset");
    $display("end of mid-run reset test");
  endtask
  // main sequence
  initial
  begin
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr_word = 12'h000;
    for (int i = 0; i < 32; i++)
      fmem[i] = 8'ha0 + 8'(i);
    fmem[5] = 8'h00;
    repeat (5) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    chk({accum, done}, 12'h000, "reset accum");
    chk(option_reg, 12'h03c, "reset option");
    test_literal();
    test_store();
    test_option();
    test_copy_accum();
    test_copy_file();
    test_refused();
    test_back_to_back();
    test_reset_mid();
    close_out();
  end
  // watchdog sized well beyond the roughly 46 cycles of stimulus
  initial
  begin
    #20000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
